//--- pkg/dsp_decoder_defs.vh
`ifndef DSP_DECODER_DEFS_VH
`define DSP_DECODER_DEFS_VH

// ======================================================================
// operation codes driven on op_code_out
`define OP_W              5
`define OP_NONE           5'h00
`define OP_MAGNITUDE      5'h01
`define OP_SUM_SHIFT      5'h02
`define OP_SUM_SHORT      5'h03
`define OP_SUM_LONG       5'h04
`define OP_SUM_CARRY      5'h05
`define OP_SUM_LOW        5'h06
`define OP_SUM_HIGH       5'h07
`define OP_SUM_MULTIPLIER_OPERAND_REGISTER       5'h08
`define OP_AUX_INC        5'h09
`define OP_AND_HI16       5'h0a
`define OP_PROD_ACC       5'h0b
`define OP_JUMP_ACC       5'h0c
`define OP_AUX_LOOP       5'h0d
`define OP_COND_JUMP      5'h0e
`define OP_BIT_TEST       5'h0f
`define OP_PROG_COPY      5'h10
`define OP_AUX_CMP        5'h11
`define OP_ADJ_COPY       5'h12
`define OP_CONF_DATA      5'h13
`define OP_PORT_IN        5'h14
`define OP_LOAD_SHIFT     5'h15
`define OP_LOAD_HIGH      5'h16

// ======================================================================
// match masks and patterns of the first instruction word
`define MSK_FULL          16'hffff
`define MSK_BYTE          16'hff00
`define MSK_NIBBLE        16'hf000
`define MSK_LONG_SHIFT    16'hfff0
`define MSK_COND          16'hfc00
`define MSK_CMP           16'hfffc
`define PAT_MAGNITUDE     16'hbe00
`define PAT_SUM_SHIFT     16'h2000
`define PAT_SUM_SHORT     16'hb800
`define PAT_SUM_LONG      16'hbf90
`define PAT_SUM_CARRY     16'h6000
`define PAT_SUM_LOW       16'h6200
`define PAT_SUM_HIGH      16'h6100
`define PAT_SUM_MULTIPLIER_OPERAND_REGISTER      16'h6300
`define PAT_AUX_INC       16'h7800
`define PAT_AND_HI16      16'hbe81
`define PAT_PROD_ACC      16'hbe04
`define PAT_JUMP_ACC      16'hbe20
`define PAT_AUX_LOOP      16'h7b00
`define PAT_COND_JUMP     16'he000
`define PAT_BIT_TEST      16'h6f00
`define PAT_PROG_COPY     16'ha500
`define PAT_AUX_CMP       16'hbf44
`define PAT_ADJ_COPY      16'h7700
`define PAT_CONF_DATA     16'hbe44
`define PAT_PORT_IN       16'haf00
`define PAT_LOAD_SHIFT    16'h1000
`define PAT_LOAD_HIGH     16'h6a00

// ======================================================================
// word and cycle figures, condition select codes
`define WORDS_ONE         2'h1
`define WORDS_TWO         2'h2
`define CYC_ONE           3'h1
`define CYC_TWO           3'h2
`define CYC_THREE         3'h3
`define CYC_FOUR          3'h4
`define CYC_FALL          3'h2
`define CYC_FALL_PIN      3'h3
`define TP_PIN_LOW        2'h0
`define TP_TC_SET         2'h1
`define TP_TC_CLEAR       2'h2
`define TP_NONE           2'h3

`endif

//--- core/pin_sync3.v
`timescale 1ns/1ns
// ======================================================================
// three-stage pin synchroniser, level follows when stages two and three agree
module pin_sync3
(
   input  wire clk_in,
   input  wire srst_in,
   input  wire pin_in,
   output reg  level_out
);
   reg stage1;
   reg stage2;
   reg stage3;

   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         stage1    <= 1'b1;
         stage2    <= 1'b1;
         stage3    <= 1'b1;
         level_out <= 1'b1;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
            level_out <= stage3;
      end
   end
endmodule

//--- core/cond_eval.v
`timescale 1ns/1ns
`include "dsp_decoder_defs.vh"
// ======================================================================
// condition check for conditional jumps
module cond_eval
(
   input  wire [1:0] condition_select_bits_in,
   input  wire [3:0] flag_states_in,
   input  wire [3:0] flag_mask_in,
   input  wire [3:0] flags_in,
   input  wire       test_control_flag_in,
   input  wire       pin_low_in,
   output wire       met_out
);
   reg select_ok;

   always @*
   begin
      case (condition_select_bits_in)
         `TP_PIN_LOW  : select_ok = pin_low_in;
         `TP_TC_SET   : select_ok = test_control_flag_in;
         `TP_TC_CLEAR : select_ok = ~test_control_flag_in;
         `TP_NONE     : select_ok = 1'b1;
         default      : select_ok = 1'b1;
      endcase
   end

   // masked flags must equal the required states
   assign met_out = select_ok &
                    (((flags_in ^ flag_states_in) & flag_mask_in) == 4'h0);
endmodule

//--- core/dsp_opcode_decoder.v
`timescale 1ns/1ns
`include "dsp_decoder_defs.vh"
// Notes on behaviour
// - accumulator magnitude word, one cycle
// - top nibble 0010: shifted operand add
// - short constant add, one cycle
// - long shifted constant add, two words
// - operand plus carry add, one cycle
// - low unextended and high accumulator sum_unextended_low
// - add shifted by multiplier operand register
// - constant added to selected aux register
// - and with constant shifted sixteen, two words
// - product register added to accumulator
// - jump via accumulator, four cycles
// - aux nonzero loop jump, four or two
// - no overflow jump, four or two
// - branch pin low jump, four or three
// - register selected bit test sets flag
// - program to data copy, three cycles
// - aux compare with index, one cycle
// - adjacent word copy, one cycle
// - configure block as data memory
// - port input, two words two cycles
// - accumulator load shifted or high half
// - condition select bits meaning
// - flag nibble mask and state match

module dsp_opcode_decoder
#(
   parameter WORD_W = 16,
   parameter CNT_W  = 3
)
(
   input  wire              clk_in,
   input  wire              srst_in,
   input  wire [WORD_W-1:0] instr_word_in,
   input  wire              instr_valid_in,
   input  wire              acc_zero_in,
   input  wire              acc_neg_in,
   input  wire              overflow_in,
   input  wire              carry_in,
   input  wire              test_control_flag_in,
   input  wire              aux_nonzero_in,
   input  wire              io_branch_pin_in,
   output wire              instr_ready_out,
   output reg               op_valid_out,
   output reg  [`OP_W-1:0]  op_code_out,
   output reg  [3:0]        shift_amount_field_out,
   output reg  [7:0]        operand_address_field_out,
   output reg  [WORD_W-1:0] constant_field_out,
   output reg  [WORD_W-1:0] second_word_out,
   output reg  [1:0]        compare_mode_bits_out,
   output reg               branch_taken_out,
   output reg  [1:0]        word_count_out,
   output reg  [CNT_W-1:0]  cycle_count_out,
   output reg               unknown_word_out
);

   // ===================================================================
   // sequencer states
   localparam S_IDLE   = 2'b00;
   localparam S_SECOND = 2'b01;
   localparam S_STALL  = 2'b10;

   reg [1:0]        state;
   reg [1:0]        next_state;
   reg [`OP_W-1:0]  held_op;
   reg [WORD_W-1:0] held_word;
   reg [CNT_W-1:0]  held_cyc;
   reg [CNT_W-1:0]  remaining;
   reg [CNT_W-1:0]  next_remaining;

   reg [`OP_W-1:0]  d_op;
   reg [1:0]        d_words;
   reg [CNT_W-1:0]  d_cyc;
   reg [CNT_W-1:0]  fin_cyc;
   reg              fin_taken;

   wire             pin_level;
   wire             cond_met;
   wire             take_first;
   wire             take_second;

   assign instr_ready_out = (state != S_STALL);
   assign take_first      = instr_valid_in & (state == S_IDLE);
   assign take_second     = instr_valid_in & (state == S_SECOND);

   // ===================================================================
   // branch pin synchroniser
   pin_sync3 u_pin_sync
   (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .pin_in    (io_branch_pin_in),
      .level_out (pin_level)
   );

   // ===================================================================
   // condition check on the held first word
   cond_eval u_cond
   (
      .condition_select_bits_in (held_word[9:8]),
      .flag_states_in           (held_word[7:4]),
      .flag_mask_in             (held_word[3:0]),
      .flags_in                 ({acc_zero_in, acc_neg_in, overflow_in, carry_in}),
      .test_control_flag_in     (test_control_flag_in),
      .pin_low_in               (~pin_level),
      .met_out                  (cond_met)
   );

   // ===================================================================
   // first word pattern match
   always @*
   begin
      d_op = `OP_NONE;

      if ((instr_word_in & `MSK_FULL) == `PAT_MAGNITUDE)
         d_op = `OP_MAGNITUDE;

      else if ((instr_word_in & `MSK_NIBBLE) == `PAT_SUM_SHIFT)
         d_op = `OP_SUM_SHIFT;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_SUM_SHORT)
         d_op = `OP_SUM_SHORT;

      else if ((instr_word_in & `MSK_LONG_SHIFT) == `PAT_SUM_LONG)
         d_op = `OP_SUM_LONG;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_SUM_CARRY)
         d_op = `OP_SUM_CARRY;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_SUM_LOW)
         d_op = `OP_SUM_LOW;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_SUM_HIGH)
         d_op = `OP_SUM_HIGH;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_SUM_MULTIPLIER_OPERAND_REGISTER)
         d_op = `OP_SUM_MULTIPLIER_OPERAND_REGISTER;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_AUX_INC)
         d_op = `OP_AUX_INC;

      else if ((instr_word_in & `MSK_FULL) == `PAT_AND_HI16)
         d_op = `OP_AND_HI16;

      else if ((instr_word_in & `MSK_FULL) == `PAT_PROD_ACC)
         d_op = `OP_PROD_ACC;

      else if ((instr_word_in & `MSK_FULL) == `PAT_JUMP_ACC)
         d_op = `OP_JUMP_ACC;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_AUX_LOOP)
         d_op = `OP_AUX_LOOP;

      else if ((instr_word_in & `MSK_COND) == `PAT_COND_JUMP)
         d_op = `OP_COND_JUMP;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_BIT_TEST)
         d_op = `OP_BIT_TEST;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_PROG_COPY)
         d_op = `OP_PROG_COPY;

      else if ((instr_word_in & `MSK_CMP) == `PAT_AUX_CMP)
         d_op = `OP_AUX_CMP;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_ADJ_COPY)
         d_op = `OP_ADJ_COPY;

      else if ((instr_word_in & `MSK_FULL) == `PAT_CONF_DATA)
         d_op = `OP_CONF_DATA;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_PORT_IN)
         d_op = `OP_PORT_IN;

      else if ((instr_word_in & `MSK_NIBBLE) == `PAT_LOAD_SHIFT)
         d_op = `OP_LOAD_SHIFT;

      else if ((instr_word_in & `MSK_BYTE) == `PAT_LOAD_HIGH)
         d_op = `OP_LOAD_HIGH;
   end

   // ===================================================================
   // word count and full cycle figure of each operation
   always @*
   begin
      case (d_op)
         `OP_SUM_LONG  : {d_words, d_cyc} = {`WORDS_TWO, `CYC_TWO};
         `OP_AND_HI16  : {d_words, d_cyc} = {`WORDS_TWO, `CYC_TWO};
         `OP_JUMP_ACC  : {d_words, d_cyc} = {`WORDS_ONE, `CYC_FOUR};
         `OP_AUX_LOOP  : {d_words, d_cyc} = {`WORDS_TWO, `CYC_FOUR};
         `OP_COND_JUMP : {d_words, d_cyc} = {`WORDS_TWO, `CYC_FOUR};
         `OP_PROG_COPY : {d_words, d_cyc} = {`WORDS_TWO, `CYC_THREE};
         `OP_PORT_IN   : {d_words, d_cyc} = {`WORDS_TWO, `CYC_TWO};

         default       : {d_words, d_cyc} = {`WORDS_ONE, `CYC_ONE};
      endcase
   end

   // ===================================================================
   // branch outcome and final cycle figure of a two-word operation
   always @*
   begin
      fin_taken = 1'b0;
      fin_cyc   = held_cyc;

      if (held_op == `OP_AUX_LOOP)
      begin
         fin_taken = aux_nonzero_in;
         fin_cyc   = aux_nonzero_in ? `CYC_FOUR : `CYC_FALL;
      end

      else if (held_op == `OP_COND_JUMP)
      begin
         fin_taken = cond_met;
         if (cond_met)
            fin_cyc = `CYC_FOUR;
         else if (held_word[9:8] == `TP_PIN_LOW)
            fin_cyc = `CYC_FALL_PIN;
         else
            fin_cyc = `CYC_FALL;
      end
   end

   // ===================================================================
   // sequencer next state
   always @*
   begin
      next_state     = state;
      next_remaining = remaining;
      case (state)
         S_IDLE:
         begin
            if (take_first && (d_words == `WORDS_TWO))
               next_state = S_SECOND;
            else if (take_first && (d_cyc != `CYC_ONE))
            begin
               next_state     = S_STALL;
               next_remaining = d_cyc - `CYC_ONE;
            end
         end

         S_SECOND:
         begin
            if (take_second && (fin_cyc != `CYC_TWO))
            begin
               next_state     = S_STALL;
               next_remaining = fin_cyc - `CYC_TWO;
            end
            else if (take_second)
               next_state = S_IDLE;
         end

         S_STALL:
         begin
            next_remaining = remaining - `CYC_ONE;
            if (remaining == `CYC_ONE)
               next_state = S_IDLE;
         end

         default:
         begin
            next_state     = S_IDLE;
            next_remaining = {CNT_W{1'b0}};
         end
      endcase
   end

   // ===================================================================
   // state, held first word and decoded outputs
   always @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state                     <= S_IDLE;
         remaining                 <= {CNT_W{1'b0}};
         held_op                   <= `OP_NONE;
         held_word                 <= {WORD_W{1'b0}};
         held_cyc                  <= {CNT_W{1'b0}};

         op_valid_out              <= 1'b0;
         op_code_out               <= `OP_NONE;
         shift_amount_field_out    <= 4'h0;
         operand_address_field_out <= 8'h00;
         constant_field_out        <= {WORD_W{1'b0}};
         second_word_out           <= {WORD_W{1'b0}};
         compare_mode_bits_out     <= 2'h0;
         branch_taken_out          <= 1'b0;
         word_count_out            <= 2'h0;
         cycle_count_out           <= {CNT_W{1'b0}};
         unknown_word_out          <= 1'b0;
      end
      else
      begin
         state            <= next_state;
         remaining        <= next_remaining;
         op_valid_out     <= 1'b0;
         unknown_word_out <= 1'b0;

         if (take_first)
         begin
            held_op   <= d_op;
            held_word <= instr_word_in;
            held_cyc  <= d_cyc;
         end

         if (take_first && (d_words == `WORDS_ONE))
         begin
            op_valid_out              <= (d_op != `OP_NONE);
            unknown_word_out          <= (d_op == `OP_NONE);
            op_code_out               <= d_op;
            operand_address_field_out <= instr_word_in[7:0];
            constant_field_out        <= {8'h00, instr_word_in[7:0]};
            compare_mode_bits_out     <= instr_word_in[1:0];
            shift_amount_field_out    <= instr_word_in[11:8];
            second_word_out           <= {WORD_W{1'b0}};
            branch_taken_out          <= (d_op == `OP_JUMP_ACC);
            word_count_out            <= d_words;
            cycle_count_out           <= d_cyc;
         end

         else if (take_second)
         begin
            op_valid_out              <= 1'b1;
            op_code_out               <= held_op;
            operand_address_field_out <= held_word[7:0];
            constant_field_out        <= instr_word_in;
            compare_mode_bits_out     <= 2'h0;
            shift_amount_field_out    <= held_word[3:0];
            second_word_out           <= instr_word_in;
            branch_taken_out          <= fin_taken;
            word_count_out            <= `WORDS_TWO;
            cycle_count_out           <= fin_cyc;
         end
      end
   end
endmodule

//--- tb/dsp_opcode_decoder_asserts.sv
`timescale 1ns/1ns
`include "dsp_decoder_defs.vh"
// ======================================================================
// decoder port checker
module dsp_opcode_decoder_asserts
#(
   parameter WORD_W = 16,
   parameter CNT_W  = 3
)
(
   input wire              clk_in,
   input wire              srst_in,
   input wire [WORD_W-1:0] instr_word_in,
   input wire              instr_valid_in,
   input wire              acc_zero_in,
   input wire              acc_neg_in,
   input wire              overflow_in,
   input wire              carry_in,
   input wire              test_control_flag_in,
   input wire              aux_nonzero_in,
   input wire              io_branch_pin_in,
   input wire              instr_ready_out,
   input wire              op_valid_out,
   input wire [`OP_W-1:0]  op_code_out,
   input wire [3:0]        shift_amount_field_out,
   input wire [7:0]        operand_address_field_out,
   input wire [WORD_W-1:0] constant_field_out,
   input wire [WORD_W-1:0] second_word_out,
   input wire [1:0]        compare_mode_bits_out,
   input wire              branch_taken_out,
   input wire [1:0]        word_count_out,
   input wire [CNT_W-1:0]  cycle_count_out,
   input wire              unknown_word_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   // ======================================================================
   // tracking of first and second words
   reg              second_pend;
   reg [WORD_W-1:0] first_w;
   wire             take        = instr_valid_in && instr_ready_out;
   wire             first_take  = take && !second_pend;
   wire             second_take = take && second_pend;
   wire [15:0]      w           = instr_word_in;
   wire             two_w = (w[15:4] == 12'hbf9) || (w == 16'hbe81) || (w[15:8] == 8'h7b) ||
                            (w[15:10] == 6'h38) || (w[15:8] == 8'ha5) || (w[15:8] == 8'haf);
   wire             tp_ok = (first_w[9:8] == 2'h1) ? test_control_flag_in :
                            (first_w[9:8] == 2'h2) ? !test_control_flag_in : 1'h1;
   wire [3:0]       flg   = {acc_zero_in, acc_neg_in, overflow_in, carry_in};
   wire             met   = tp_ok && (((flg ^ first_w[7:4]) & first_w[3:0]) == 4'h0);
   always @(posedge clk_in)
      if (srst_in)
         second_pend <= 1'h0;
      else if (take)
      begin
         second_pend <= first_take && two_w;
         if (first_take)
            first_w <= w;
      end
   // ======================================================================
   // properties
   property p_magnitude;
      first_take && w == 16'hbe00 |=> op_valid_out && op_code_out == `OP_MAGNITUDE &&
         cycle_count_out == 3'h1 && word_count_out == 2'h1;
   endproperty
   a_magnitude: assert property (p_magnitude) else $error("magnitude decode wrong");
   property p_shift_load;
      first_take && (w[15:12] == 4'h2 || w[15:12] == 4'h1) |=> op_valid_out &&
         shift_amount_field_out == $past(w[11:8]) && operand_address_field_out == $past(w[7:0]);
   endproperty
   a_shift_load: assert property (p_shift_load) else $error("bad fields");
   property p_short_const;
      first_take && (w[15:8] == 8'hb8 || w[15:8] == 8'h78) |=> op_valid_out &&
         cycle_count_out == 3'h1 && constant_field_out == {8'h00, $past(w[7:0])};
   endproperty
   a_short_const: assert property (p_short_const) else $error("bad const");
   property p_two_two;
      second_take && (first_w[15:4] == 12'hbf9 || first_w == 16'hbe81 || first_w[15:8] == 8'haf)
         |=> op_valid_out && word_count_out == 2'h2 && cycle_count_out == 3'h2 &&
         constant_field_out == $past(w);
   endproperty
   a_two_two: assert property (p_two_two) else $error("two word");
   property p_jump_acc;
      first_take && w == 16'hbe20 |=> op_valid_out && branch_taken_out && cycle_count_out == 3'h4
         && !instr_ready_out ##1 (!instr_ready_out) [*2] ##1 instr_ready_out;
   endproperty
   a_jump_acc: assert property (p_jump_acc) else $error("accumulator jump wrong");
   property p_taken_stall;
      op_valid_out && word_count_out == 2'h2 && branch_taken_out |-> cycle_count_out == 3'h4 &&
         !instr_ready_out ##1 !instr_ready_out ##1 instr_ready_out;
   endproperty
   a_taken_stall: assert property (p_taken_stall) else $error("bad stall");
   property p_prog_copy;
      second_take && first_w[15:8] == 8'ha5 |=> op_valid_out && op_code_out == `OP_PROG_COPY &&
         cycle_count_out == 3'h3 && !instr_ready_out ##1 instr_ready_out;
   endproperty
   a_prog_copy: assert property (p_prog_copy) else $error("program copy wrong");
   property p_cond_met;
      second_take && first_w[15:10] == 6'h38 && first_w[9:8] != 2'h0 |=>
         branch_taken_out == $past(met) && cycle_count_out == (branch_taken_out ? 3'h4 : 3'h2);
   endproperty
   a_cond_met: assert property (p_cond_met) else $error("bad condition");
   property p_aux_loop;
      second_take && first_w[15:8] == 8'h7b |=> op_code_out == `OP_AUX_LOOP &&
         branch_taken_out == $past(aux_nonzero_in);
   endproperty
   a_aux_loop: assert property (p_aux_loop) else $error("aux loop outcome wrong");
   property p_compare;
      first_take && w[15:2] == 14'h2fd1 |=> op_code_out == `OP_AUX_CMP &&
         compare_mode_bits_out == $past(w[1:0]);
   endproperty
   a_compare: assert property (p_compare) else $error("compare mode wrong");
   property p_no_stall;
      op_valid_out && cycle_count_out == {1'h0, word_count_out} |-> instr_ready_out;
   endproperty
   a_no_stall: assert property (p_no_stall) else $error("needless stall");
endmodule

//--- tb/prog_mem_model.sv
`timescale 1ns/1ns
// ======================================================================
// program memory: presents a word and holds it until taken
module prog_mem_model
(
   input  wire        clk_in,
   input  wire        srst_in,
   input  wire        ready_in,
   output reg  [15:0] word_out,
   output reg         valid_out
);
   initial
   begin
      word_out = 16'h0000;
      valid_out = 1'h0;
   end
   task send(input [15:0] word, input integer gap);
   begin
      if (gap > 0)
      begin
         valid_out <= 1'h0;
         word_out <= ~word_out;
         repeat (gap) @(posedge clk_in);
      end
      valid_out <= 1'h1;
      word_out <= word;
      @(posedge clk_in);
      while (ready_in !== 1'h1)
         @(posedge clk_in);
   end
   endtask
   // released bus shows the inverse of the last word
   task release_bus;
   begin
      valid_out <= 1'h0;
      word_out <= ~word_out;
   end
   endtask
endmodule

//--- tb/dsp_opcode_decoder_tb_top.sv
`timescale 1ns/1ns
`include "dsp_decoder_defs.vh"
module dsp_opcode_decoder_tb_top;
   logic        clk_in = 1'h0, srst_in = 1'h1, acc_zero_in = 1'h0, acc_neg_in = 1'h0;
   logic        overflow_in = 1'h0, carry_in = 1'h0, test_control_flag_in = 1'h0;
   logic        aux_nonzero_in = 1'h0, io_branch_pin_in = 1'h1;
   wire  [15:0] instr_word_in, constant_field_out, second_word_out;
   wire         instr_valid_in, instr_ready_out, op_valid_out, branch_taken_out, unknown_word_out;
   wire  [4:0]  op_code_out;
   wire  [3:0]  shift_amount_field_out;
   wire  [7:0]  operand_address_field_out;
   wire  [1:0]  compare_mode_bits_out, word_count_out;
   wire  [2:0]  cycle_count_out;
   integer      errors = 0, checks = 0, n, k, dummy;
   logic [57:0] q [$];
   logic [57:0] exp_v, got_exp, seen;
   logic [15:0] w, r;
   always #5 clk_in = ~clk_in;
   dsp_opcode_decoder #(.WORD_W(16), .CNT_W(3)) u_dut (.*);
   prog_mem_model u_mem (.clk_in(clk_in), .srst_in(srst_in), .ready_in(instr_ready_out),
                         .word_out(instr_word_in), .valid_out(instr_valid_in));
   // ======================================================================
   // expectation and issue of one instruction
   task issue(input [15:0] wd, input [15:0] sd, input [5:0] f, input pin, input integer gap);
      logic [4:0] op;
      logic       two, bt, unk, met, tp_ok;
      logic [2:0] cc, cj;
   begin
      {op, two, bt, unk, cc} = {`OP_NONE, 3'h0, 3'h1};
      tp_ok = (wd[9:8] == 2'h0) ? !pin : (wd[9:8] == 2'h1) ? f[1] :
              (wd[9:8] == 2'h2) ? !f[1] : 1'h1;
      met = tp_ok && (((f[5:2] ^ wd[7:4]) & wd[3:0]) == 4'h0);
      cj = met ? 3'h4 : (wd[9:8] == 2'h0) ? 3'h3 : 3'h2;
      casez (wd)
         16'hbe00: op = `OP_MAGNITUDE;
         16'h2???: op = `OP_SUM_SHIFT;
         16'hb8??: op = `OP_SUM_SHORT;
         16'hbf9?: {op, two, cc} = {`OP_SUM_LONG, 1'h1, 3'h2};
         16'h60??: op = `OP_SUM_CARRY;
         16'h62??: op = `OP_SUM_LOW;
         16'h61??: op = `OP_SUM_HIGH;
         16'h63??: op = `OP_SUM_MULTIPLIER_OPERAND_REGISTER;
         16'h78??: op = `OP_AUX_INC;
         16'hbe81: {op, two, cc} = {`OP_AND_HI16, 1'h1, 3'h2};
         16'hbe04: op = `OP_PROD_ACC;
         16'hbe20: {op, bt, cc} = {`OP_JUMP_ACC, 1'h1, 3'h4};
         16'h7b??: {op, two, bt, cc} = {`OP_AUX_LOOP, 1'h1, f[0], f[0] ? 3'h4 : 3'h2};
         16'he???: {op, two, bt, cc} = {`OP_COND_JUMP, 1'h1, met, cj};
         16'h6f??: op = `OP_BIT_TEST;
         16'ha5??: {op, two, cc} = {`OP_PROG_COPY, 1'h1, 3'h3};
         16'hbf4?: op = `OP_AUX_CMP;
         16'h77??: op = `OP_ADJ_COPY;
         16'hbe44: op = `OP_CONF_DATA;
         16'haf??: {op, two, cc} = {`OP_PORT_IN, 1'h1, 3'h2};
         16'h1???: op = `OP_LOAD_SHIFT;
         16'h6a??: op = `OP_LOAD_HIGH;
         default: unk = 1'h1;
      endcase
      if (two)
         exp_v = {unk, op, wd[3:0], wd[7:0], sd, sd, 2'h0, bt, 2'h2, cc};
      else
         exp_v = {unk, op, wd[11:8], wd[7:0], 8'h00, wd[7:0], 16'h0000, wd[1:0], bt, 2'h1, cc};
      q.push_back(exp_v);
      {acc_zero_in, acc_neg_in, overflow_in, carry_in, test_control_flag_in, aux_nonzero_in} <= f;
      io_branch_pin_in <= pin;
      // the pin synchroniser needs settling time before a pin test
      u_mem.send(wd, (op == `OP_COND_JUMP && wd[9:8] == 2'h0) ? 6 : gap);
      if (two)
         u_mem.send(sd, gap);
   end
   endtask
   // ======================================================================
   // result monitor
   always @(negedge clk_in)
      if (op_valid_out === 1'h1 || unknown_word_out === 1'h1)
      begin
         seen = {unknown_word_out & ~op_valid_out, op_code_out, shift_amount_field_out,
                 operand_address_field_out, constant_field_out, second_word_out,
                 compare_mode_bits_out, branch_taken_out, word_count_out, cycle_count_out};
         got_exp = (q.size() > 0) ? q.pop_front() : ~58'h0;
         checks = checks + 1;
         if (seen !== got_exp)
         begin
            errors = errors + 1;
            $display("FAIL decode expected %h seen %h", got_exp, seen);
         end
      end
   task tally_and_finish;
   begin
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   // ======================================================================
   // main sequence and watchdog
   initial
   begin
      dummy = $urandom(32'h81d8_a10a);
      repeat (3) @(posedge clk_in);
      srst_in <= 1'h0;
      for (n = 0; n < 400; n = n + 1)
      begin
         r = 16'($urandom);
         k = (n < 48) ? n % 24 : $urandom % 24;
         case (k)
            0: w = 16'hbe00;
            1: w = {4'h2, r[11:0]};
            2: w = {8'hb8, r[7:0]};
            3: w = {12'hbf9, r[3:0]};
            4: w = {8'h60, r[7:0]};
            5: w = {8'h62, r[7:0]};
            6: w = {8'h61, r[7:0]};
            7: w = {8'h63, r[7:0]};
            8: w = {8'h78, r[7:0]};
            9: w = 16'hbe81;
            10: w = 16'hbe04;
            11: w = 16'hbe20;
            12: w = {8'h7b, r[7:0]};
            13: w = {6'h38, r[9:0]};
            14: w = {8'h6f, r[7:0]};
            15: w = {8'ha5, r[7:0]};
            16: w = {14'h2fd1, r[1:0]};
            17: w = {8'h77, r[7:0]};
            18: w = 16'hbe44;
            19: w = {8'haf, r[7:0]};
            20: w = {4'h1, r[11:0]};
            21: w = {8'h6a, r[7:0]};
            22: w = 16'h8b00;
            default: w = 16'ha860; // matches no pattern, decoded as unknown and flagged on unknown_word_out
         endcase
         issue(w, 16'($urandom), 6'($urandom), 1'($urandom), $urandom % 3);
      end
      u_mem.release_bus();
      repeat (8) @(posedge clk_in);
      if (q.size() != 0)
      begin
         errors = errors + 1;
         $display("FAIL pending expected %0d seen %0d", 0, q.size());
      end
      tally_and_finish();
   end
   initial
   begin
      #100000;
      errors = errors + 1;
      tally_and_finish();
   end
endmodule
bind dsp_opcode_decoder dsp_opcode_decoder_asserts #(.WORD_W(WORD_W), .CNT_W(CNT_W)) u_chk (.*);
